// [core/vt_monitor_pkg.sv]
// Constants and types for the voltage and temperature monitor sequencer
package vt_monitor_pkg;

    // ------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CLK_MHZ = 125;
    localparam int SLOT_US = 1000;
    localparam int SLOT_CYCLES = SLOT_US * CLK_MHZ;
    localparam int CNT_W = 17;

    // ------------------------------------------------------------
    // Register map, all within 0x15 to 0x1B
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h15;
    localparam logic [ADDR_W-1:0] REG_THR_HI = 8'h16;
    localparam logic [ADDR_W-1:0] REG_THR_LO = 8'h17;
    localparam logic [ADDR_W-1:0] REG_RES_SEL = 8'h18;
    localparam logic [ADDR_W-1:0] REG_RES_DATA = 8'h19;
    localparam logic [ADDR_W-1:0] REG_ALARM = 8'h1A;
    localparam logic [ADDR_W-1:0] REG_ALARM_MASK = 8'h1B;

    // CTRL fields
    localparam int CTRL_MON_EN = 0;
    localparam int CTRL_EN_A = 1;
    localparam int CTRL_EN_B = 2;
    localparam int CTRL_EN_T = 3;
    // RES_SEL: [1:0] sensor index for results/thresholds
    localparam int SEL_W = 2;
    // ALARM bits
    localparam int ALM_A = 0;
    localparam int ALM_B = 1;
    localparam int ALM_T = 2;
    localparam int N_SENS = 3;

    localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
    localparam logic [DATA_W-1:0] THR_HI_RST = 8'hFF;
    localparam logic [DATA_W-1:0] THR_LO_RST = 8'h00;
    localparam logic [N_SENS-1:0] MASK_RST = 3'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_PICK = 4'h2,
        ST_MEAS = 4'h4,
        ST_DONE = 4'h8
    } seq_state_e;

    typedef struct packed {
        logic [DATA_W-1:0] sense_a;
        logic [DATA_W-1:0] sense_b;
        logic [DATA_W-1:0] temp;
    } sample_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

endpackage

// [core/vt_monitor_seq.sv]
// Voltage and temperature monitor sequencer with register port and alarms
// Function
// - Each voltage-sense pin has its own high and low threshold.
// - Pin voltage above high or below low sets that pin's alarm bit.
// - Raised alarms are driven out for transfer to the remote deserializer.
// - Die temperature outside its range sets the temperature alarm bit.
// - Measurements run one at a time in rotating turn.
// - Rotation starts only once the reset sequencer reports normal state.
// - Each measurement slot lasts 1 ms.
// - Each result is written into that sensor's readable result register.
// - Monitoring is off after reset until software enables it.
// - Disabled sensors are skipped in the rotation.
// - Pins a and b sense voltage; pins c and d stay plain signalling.
// - All monitor registers sit at addresses 0x15 through 0x1B.
`timescale 1ns/10ps
module vt_monitor_seq (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_normal_mode,
    input wire vt_monitor_pkg::sample_s i_sample,
    input wire logic i_pin_c,
    input wire logic i_pin_d,
    output logic o_pin_c,
    output logic o_pin_d,
    input wire vt_monitor_pkg::reg_req_s i_req,
    output logic [vt_monitor_pkg::DATA_W-1:0] o_rdata,
    output logic [vt_monitor_pkg::N_SENS-1:0] o_alarm_link,
    output logic [vt_monitor_pkg::SEL_W-1:0] o_meas_sel,
    output logic o_meas_active,
    output logic o_irq
);
    import vt_monitor_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        seq_state_e st;
        logic [CNT_W-1:0] cnt;
        logic [SEL_W-1:0] cur;
        logic [DATA_W-1:0] ctrl;
        logic [N_SENS-1:0][DATA_W-1:0] thr_hi;
        logic [N_SENS-1:0][DATA_W-1:0] thr_lo;
        logic [N_SENS-1:0][DATA_W-1:0] result;
        logic [SEL_W-1:0] sel;
        logic [N_SENS-1:0] alarm;
        logic [N_SENS-1:0] mask;
        logic [DATA_W-1:0] rdata;
    } state_s;

    localparam logic [CNT_W-1:0] SLOT_LAST = CNT_W'(SLOT_CYCLES - 1);
    localparam logic [SEL_W-1:0] IDX_A = SEL_W'(ALM_A);
    localparam logic [SEL_W-1:0] IDX_B = SEL_W'(ALM_B);
    // Index 3 names no sensor
    localparam logic [SEL_W-1:0] IDX_NONE = SEL_W'(N_SENS);
    localparam logic [SEL_W-1:0] IDX_T = SEL_W'(ALM_T);

    state_s s_r;
    state_s s_nxt;

    logic [N_SENS-1:0] sens_en;
    logic [N_SENS-1:0] meas_alarm;
    logic [N_SENS-1:0] clr_bits;
    logic [DATA_W-1:0] cur_val;
    logic [SEL_W-1:0] next_idx;
    logic any_en;
    logic run;
    logic sel_ok;

    // Per-sensor window compare results
    logic [N_SENS-1:0] above;
    logic [N_SENS-1:0] below;

    // ------------------------------------------------------------
    // Sensor selection
    // ------------------------------------------------------------
    assign sens_en = {s_r.ctrl[CTRL_EN_T], s_r.ctrl[CTRL_EN_B], s_r.ctrl[CTRL_EN_A]};
    assign any_en = |sens_en;
    assign run = s_r.ctrl[CTRL_MON_EN] && i_normal_mode && any_en;
    assign sel_ok = (s_r.sel != IDX_NONE);

    // Next enabled sensor after the current one, wrapping
    always_comb begin
        logic [SEL_W-1:0] k;
        logic found;
        k = s_r.cur;
        found = 1'b0;
        next_idx = s_r.cur;
        for (int i = 0; i < N_SENS; i++) begin
            k = (k == IDX_T) ? IDX_A : SEL_W'(k + 1'b1);
            if (sens_en[k] && !found) begin
                next_idx = k;
                found = 1'b1;
            end
        end
    end

    // Value of the sensor owning the slot
    always_comb begin
        case (s_r.cur)
            IDX_A: begin
                cur_val = i_sample.sense_a;
            end
            IDX_B: begin
                cur_val = i_sample.sense_b;
            end
            default: begin
                cur_val = i_sample.temp;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Window checks
    // ------------------------------------------------------------
    // One comparator pair per sensor; only the owner's result is used
    genvar g;
    generate
        for (g = 0; g < N_SENS; g++) begin : g_win
            assign above[g] = cur_val > s_r.thr_hi[g];
            assign below[g] = cur_val < s_r.thr_lo[g];
            assign meas_alarm[g] = above[g] || below[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        clr_bits = '0;

        case (s_r.st)
            ST_IDLE: begin
                s_nxt.cnt = '0;
                if (run) begin
                    s_nxt.st = ST_PICK;
                end
            end

            ST_PICK: begin
                // Start on the current slot if enabled, else move on
                if (!run) begin
                    s_nxt.st = ST_IDLE;
                end else begin
                    if (!sens_en[s_r.cur]) begin
                        s_nxt.cur = next_idx;
                    end
                    s_nxt.cnt = '0;
                    s_nxt.st = ST_MEAS;
                end
            end

            ST_MEAS: begin
                // Only one sensor is addressed per slot
                if (!run) begin
                    s_nxt.st = ST_IDLE;
                end else if (s_r.cnt == SLOT_LAST) begin
                    s_nxt.st = ST_DONE;
                end else begin
                    s_nxt.cnt = CNT_W'(s_r.cnt + 1'b1);
                end
            end

            ST_DONE: begin
                s_nxt.result[s_r.cur] = cur_val;
                s_nxt.cur = next_idx;
                s_nxt.cnt = '0;
                s_nxt.st = run ? ST_MEAS : ST_IDLE;
            end

            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase

        // ------------------------------------------------------------
        // Register writes; unmapped addresses and index 3 are ignored
        // ------------------------------------------------------------
        if (i_req.wr) begin
            case (i_req.addr)
                REG_CTRL: begin
                    s_nxt.ctrl = i_req.wdata;
                end

                REG_THR_HI: begin
                    if (sel_ok) begin
                        s_nxt.thr_hi[s_r.sel] = i_req.wdata;
                    end
                end

                REG_THR_LO: begin
                    if (sel_ok) begin
                        s_nxt.thr_lo[s_r.sel] = i_req.wdata;
                    end
                end

                REG_RES_SEL: begin
                    s_nxt.sel = i_req.wdata[SEL_W-1:0];
                end

                REG_ALARM: begin
                    clr_bits = i_req.wdata[N_SENS-1:0];
                end

                REG_ALARM_MASK: begin
                    s_nxt.mask = i_req.wdata[N_SENS-1:0];
                end

                default: begin
                end
            endcase
        end

        // ------------------------------------------------------------
        // Alarm status; a new alarm wins over a clear in the same cycle
        // ------------------------------------------------------------
        s_nxt.alarm = s_r.alarm & ~clr_bits;
        if (s_r.st == ST_DONE && meas_alarm[s_r.cur]) begin
            s_nxt.alarm[s_r.cur] = 1'b1;
        end

        // ------------------------------------------------------------
        // Register reads, data one cycle later
        // ------------------------------------------------------------
        s_nxt.rdata = '0;
        if (i_req.rd) begin
            case (i_req.addr)
                REG_CTRL: begin
                    s_nxt.rdata = s_r.ctrl;
                end

                REG_THR_HI: begin
                    s_nxt.rdata = sel_ok ? s_r.thr_hi[s_r.sel] : '0;
                end

                REG_THR_LO: begin
                    s_nxt.rdata = sel_ok ? s_r.thr_lo[s_r.sel] : '0;
                end

                REG_RES_SEL: begin
                    s_nxt.rdata = DATA_W'(s_r.sel);
                end

                REG_RES_DATA: begin
                    s_nxt.rdata = sel_ok ? s_r.result[s_r.sel] : '0;
                end

                REG_ALARM: begin
                    s_nxt.rdata = DATA_W'(s_r.alarm);
                end

                REG_ALARM_MASK: begin
                    s_nxt.rdata = DATA_W'(s_r.mask);
                end

                default: begin
                    s_nxt.rdata = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            s_r.st <= ST_IDLE;
            s_r.cnt <= '0;
            s_r.cur <= IDX_A;
            s_r.ctrl <= CTRL_RST;
            s_r.thr_hi <= {N_SENS{THR_HI_RST}};
            s_r.thr_lo <= {N_SENS{THR_LO_RST}};
            s_r.result <= '0;
            s_r.sel <= '0;
            s_r.alarm <= '0;
            s_r.mask <= MASK_RST;
            s_r.rdata <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Pins c and d are never used for sensing, just passed through
    assign o_pin_c = i_pin_c;
    assign o_pin_d = i_pin_d;

    // ------------------------------------------------------------
    // Register port outputs
    // ------------------------------------------------------------
    assign o_rdata = s_r.rdata;

    // ------------------------------------------------------------
    // Sequencer and alarm outputs
    // ------------------------------------------------------------
    assign o_alarm_link = s_r.alarm;
    assign o_meas_sel = s_r.cur;
    assign o_meas_active = (s_r.st == ST_MEAS);
    assign o_irq = |(s_r.alarm & s_r.mask);

endmodule

// [dv/vt_monitor_chk.sv]
// Port-level assertions for the monitor sequencer
`timescale 1ns/10ps
module vt_monitor_chk (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_normal_mode,
    input wire logic i_pin_c,
    input wire logic i_pin_d,
    input wire vt_monitor_pkg::reg_req_s i_req,
    input wire logic o_pin_c,
    input wire logic o_pin_d,
    input wire logic [vt_monitor_pkg::DATA_W-1:0] o_rdata,
    input wire logic [vt_monitor_pkg::N_SENS-1:0] o_alarm_link,
    input wire logic [vt_monitor_pkg::SEL_W-1:0] o_meas_sel,
    input wire logic o_meas_active,
    input wire logic o_irq
);
    import vt_monitor_pkg::*;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    property p_irq;
        o_irq |-> |o_alarm_link;
    endproperty
    a_irq: assert property (p_irq) else $error("irq without alarm");
    property p_rdata;
        !$past(i_req.rd) |-> o_rdata == 8'h00;
    endproperty
    a_rdata: assert property (p_rdata) else $error("rdata outside read");
    property p_pins;
        o_pin_c == i_pin_c && o_pin_d == i_pin_d;
    endproperty
    a_pins: assert property (p_pins) else $error("pins c d altered");
    property p_normal;
        $rose(o_meas_active) |-> $past(i_normal_mode, 2);
    endproperty
    a_normal: assert property (p_normal) else $error("measured outside normal");
    property p_sel;
        o_meas_active |-> o_meas_sel != 2'h3;
    endproperty
    a_sel: assert property (p_sel) else $error("bad sensor index");
    property p_one;
        o_meas_active && $past(o_meas_active) |-> $stable(o_meas_sel);
    endproperty
    a_one: assert property (p_one) else $error("sensor changed in slot");
    // New alarms only land right after a slot closes
    property p_alarm;
        |(o_alarm_link & ~$past(o_alarm_link)) |-> !$past(o_meas_active) && $past(o_meas_active, 2);
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm outside slot end");
    property p_off;
        $rose(i_rst_n) |-> !o_meas_active [*2];
    endproperty
    a_off: assert property (p_off) else $error("active after reset");
    c_meas: cover property ($rose(o_meas_active));
    c_read: cover property ($past(i_req.rd) && o_rdata != 8'h00);
    c_sel_b: cover property (o_meas_active && o_meas_sel == 2'h1);
endmodule
bind vt_monitor_seq vt_monitor_chk vt_monitor_chk_i (.i_sys_clk, .i_rst_n, .i_normal_mode, .i_pin_c,
    .i_pin_d, .i_req, .o_pin_c, .o_pin_d, .o_rdata, .o_alarm_link, .o_meas_sel, .o_meas_active, .o_irq);

// [dv/alarm_link_rx.sv]
// Remote receiver model latching forwarded alarm indications
`timescale 1ns/10ps
module alarm_link_rx (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [2:0] i_alarm,
    output logic [2:0] o_seen
);
    // Sticky, so a short alarm is never missed
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_seen <= 3'h0;
        end else begin
            o_seen <= o_seen | i_alarm;
        end
    end
endmodule

// [dv/tb_vt_monitor_seq.sv]
// Self-checking bench for the monitor sequencer
`timescale 1ns/10ps
module tb_vt_monitor_seq;
    import vt_monitor_pkg::*;
    logic i_sys_clk, i_rst_n, i_normal_mode, i_pin_c, i_pin_d, o_pin_c, o_pin_d, o_meas_active, o_irq;
    sample_s i_sample;
    reg_req_s i_req;
    logic [DATA_W-1:0] o_rdata;
    logic [N_SENS-1:0] o_alarm_link, seen;
    logic [SEL_W-1:0] o_meas_sel;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    vt_monitor_seq vt_monitor_seq_i (.i_sys_clk, .i_rst_n, .i_normal_mode, .i_sample, .i_pin_c, .i_pin_d,
        .o_pin_c, .o_pin_d, .i_req, .o_rdata, .o_alarm_link, .o_meas_sel, .o_meas_active, .o_irq);
    alarm_link_rx alarm_link_rx_i (.i_sys_clk, .i_rst_n, .i_alarm(o_alarm_link), .o_seen(seen));
    initial begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            conclude();
        end
    end
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Strobe for one cycle; the idle edge keeps back-to-back calls apart
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge i_sys_clk);
        i_req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        @(negedge i_sys_clk);
        chk("rdata", exp, o_rdata);
    endtask
    task automatic act(input int n, input logic a, input logic [1:0] s);
        repeat (n) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        chk("active", {7'h00, a}, {7'h00, o_meas_active});
        chk("sel", {6'h00, s}, {6'h00, o_meas_sel});
    endtask
    initial begin
        i_rst_n = 1'b0;
        i_normal_mode = 1'b0;
        i_pin_c = 1'b1;
        i_pin_d = 1'b0;
        i_req = '0;
        i_sample = '{sense_a: 8'h40, sense_b: 8'h50, temp: 8'h60};
        repeat (4) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        rd(REG_CTRL, CTRL_RST);
        rd(REG_THR_LO, THR_LO_RST);
        rd(REG_ALARM, 8'h00);
        rd(REG_ALARM_MASK, 8'h00);
        rd(8'h14, 8'h00);
        acc(1'b1, 8'h1C, 8'h5A);
        rd(8'h1C, 8'h00);
        for (int s = 0; s < N_SENS; s++) begin
            acc(1'b1, REG_RES_SEL, 8'(s));
            rd(REG_THR_HI, THR_HI_RST);
            acc(1'b1, REG_THR_HI, 8'hA0 + 8'(s));
        end
        for (int s = 0; s < N_SENS; s++) begin
            acc(1'b1, REG_RES_SEL, 8'(s));
            rd(REG_THR_HI, 8'hA0 + 8'(s));
        end
        acc(1'b1, REG_RES_SEL, 8'h03);
        rd(REG_RES_SEL, 8'h03);
        rd(REG_THR_HI, 8'h00);
        rd(REG_RES_DATA, 8'h00);
        acc(1'b1, REG_ALARM_MASK, 8'h07);
        rd(REG_ALARM_MASK, 8'h07);
        $display("register test done");
        acc(1'b1, REG_CTRL, 8'h0F);
        act(50, 1'b0, 2'h0);
        @(posedge i_sys_clk);
        i_normal_mode <= 1'b1;
        act(4, 1'b1, 2'h0);
        act(1000, 1'b1, 2'h0);
        acc(1'b1, REG_CTRL, 8'h0E);
        act(4, 1'b0, 2'h0);
        acc(1'b1, REG_CTRL, 8'h0D);
        act(4, 1'b1, 2'h1);
        chk("pins", 8'h02, {6'h00, o_pin_c, o_pin_d});
        chk("link", 8'h00, {5'h00, seen});
        chk("irq", 8'h00, {7'h00, o_irq});
        $display("sequencer test done");
        conclude();
    end
endmodule
